// File: rtl/pbs_sizer.v
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`include "pbs_regs.vh"

// Functional notes
// - port B moves 36-bit long words, 18-bit halves or 9-bit bytes
// - format may change at run time, sampled on the port-B clock
// - two width selects plus endian select choose one of five formats
// - endian select high means little-endian, low means big-endian
// - reorder moves whole bytes, never bits inside a byte
// - read narrowing happens only at the port-B output, on full words
// - byte read shows the first byte during the access's third cycle
// - four byte reads deliver the whole long word as four pieces
// - lanes not carrying data keep their last driven values
// - byte reads use lane 0 little-endian, lane 3 big-endian
// - byte writes take lane 0 little-endian, lane 3 big-endian
// - write with both width selects high goes to the reverse mailbox
// - width matching applies to forward reads and reverse writes
// - reads: fetch, reorder, narrow; writes: widen, reorder, store
// - reorder selects: none, byte, half-word, byte and half-word
module pbs_sizer #(
  parameter LANE = 9,
  parameter COUNT_BITS = 16
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // port-B control pins
  input wire portBSelectN,
  input wire readEnable,
  input wire writeEnable,
  input wire widthSelectLo,
  input wire widthSelectHi,
  input wire endianSelectN,
  input wire reorderSelectLo,
  input wire reorderSelectHi,
  // port-B data
  input wire [4*LANE-1:0] portBDataIn,
  output reg [4*LANE-1:0] portBDataOut,
  output reg portBBusy,
  // forward queue, show-ahead
  input wire [4*LANE-1:0] fwdData,
  input wire fwdValid,
  output reg fwdPop,
  // reverse queue
  output reg [4*LANE-1:0] revData,
  output reg revPush,
  input wire revReady,
  // reverse mailbox flag
  output reg mailboxFull,
  // register bus
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest
);

  // ==========================================================
  // states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SETUP = 3'b010;
  localparam [2:0] ST_XFER = 3'b100;

  reg [2:0] state_q;
  reg [1:0] width_q;
  reg big_q;
  reg dirWrite_q;
  reg [1:0] reorder_q;
  reg [1:0] piece_q;
  reg [4*LANE-1:0] word_q;
  reg [4*LANE-1:0] mailbox_q;
  reg [COUNT_BITS-1:0] readCount_q;
  reg [COUNT_BITS-1:0] writeCount_q;
  reg enable_q;
  reg flush_q;

  // ==========================================================
  // live selections
  // pins are driven by logic on this same clock, so no synchroniser
  wire selActive = ~portBSelectN & enable_q;
  wire [1:0] widthPins = {widthSelectHi, widthSelectLo};
  wire [1:0] reorderPins = {reorderSelectHi, reorderSelectLo};
  // pieces are refused while an earlier push still waits
  wire stall = revPush & ~revReady;

  // ==========================================================
  // read path: fetch, reorder, then narrow
  wire [4*LANE-1:0] fwdReordered;

  pbs_reorder #(.LANE(LANE)) uReadReorder (
    .dataIn(fwdData),
    .mode(reorderPins),
    .dataOut(fwdReordered)
  );

  reg [4*LANE-1:0] srcWord;
  reg [1:0] srcPiece;
  reg [LANE-1:0] srcByte;
  reg [4*LANE-1:0] outNext;
  reg lastPiece;

  always @* begin
    srcWord = (state_q == ST_SETUP) ? fwdReordered : word_q;
    srcPiece = (state_q == ST_SETUP) ? 2'h0 : piece_q;
    // big-endian walks from the top lane down
    case (big_q ? (2'h3 - srcPiece) : srcPiece)
      2'h0: srcByte = srcWord[0 +: LANE];
      2'h1: srcByte = srcWord[LANE +: LANE];
      2'h2: srcByte = srcWord[2*LANE +: LANE];
      default: srcByte = srcWord[3*LANE +: LANE];
    endcase
    // unused lanes keep the value last shown
    outNext = portBDataOut;
    lastPiece = 1'b1;
    case (width_q)
      `PBS_WIDTH_BYTE: begin
        lastPiece = (srcPiece == 2'h3);
        if (big_q) begin
          outNext[3*LANE +: LANE] = srcByte;
        end else begin
          outNext[0 +: LANE] = srcByte;
        end
      end
      `PBS_WIDTH_HALF: begin
        lastPiece = srcPiece[0];
        if (big_q) begin
          outNext[2*LANE +: 2*LANE] = srcPiece[0] ?
            srcWord[0 +: 2*LANE] : srcWord[2*LANE +: 2*LANE];
        end else begin
          outNext[0 +: 2*LANE] = srcPiece[0] ?
            srcWord[2*LANE +: 2*LANE] : srcWord[0 +: 2*LANE];
        end
      end
      default: begin
        outNext = srcWord;
      end
    endcase
  end

  // ==========================================================
  // write path: widen, reorder, then store
  wire narrowWrite = (width_q == `PBS_WIDTH_BYTE) ||
    (width_q == `PBS_WIDTH_HALF);
  wire byteMode = (width_q == `PBS_WIDTH_BYTE);
  wire xferWrite = (state_q == ST_XFER) & dirWrite_q & selActive &
    writeEnable & ~stall;
  wire [2*LANE-1:0] pieceIn = byteMode ?
    {{LANE{1'b0}}, big_q ? portBDataIn[3*LANE +: LANE] :
      portBDataIn[0 +: LANE]} :
    (big_q ? portBDataIn[2*LANE +: 2*LANE] : portBDataIn[0 +: 2*LANE]);
  wire [4*LANE-1:0] gatherWord;
  wire [2:0] gatherCount;
  wire gatherDone;

  pbs_gather #(.LANE(LANE)) uGather (
    .clk(clk),
    .reset(reset),
    .clear(flush_q),
    .pieceValid(xferWrite & narrowWrite),
    .byteMode(byteMode),
    .bigEndian(big_q),
    .pieceData(pieceIn),
    .word_q(gatherWord),
    .count_q(gatherCount),
    .done_q(gatherDone)
  );

  wire [4*LANE-1:0] revSource = narrowWrite ? gatherWord : portBDataIn;
  wire [4*LANE-1:0] revReordered;

  pbs_reorder #(.LANE(LANE)) uWriteReorder (
    .dataIn(revSource),
    .mode(reorder_q),
    .dataOut(revReordered)
  );

  // ==========================================================
  // transfer sequencer
  reg mailboxClear;
  // counters simply wrap; software takes differences between reads
  wire [COUNT_BITS-1:0] countOne = {{(COUNT_BITS-1){1'b0}}, 1'b1};
  // mailbox write lands in the transfer state, pieces never gather
  wire mailWrite = (state_q == ST_XFER) & xferWrite &
    (width_q == `PBS_WIDTH_MAIL);

  always @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      width_q <= `PBS_WIDTH_LONG;
      big_q <= 1'b0;
      dirWrite_q <= 1'b0;
      reorder_q <= `PBS_REORDER_NONE;
      piece_q <= 2'h0;
      word_q <= {4*LANE{1'b0}};
      portBDataOut <= {4*LANE{1'b0}};
      fwdPop <= 1'b0;
      revData <= {4*LANE{1'b0}};
      revPush <= 1'b0;
      portBBusy <= 1'b0;
      mailbox_q <= {4*LANE{1'b0}};
      mailboxFull <= 1'b0;
      readCount_q <= {COUNT_BITS{1'b0}};
      writeCount_q <= {COUNT_BITS{1'b0}};
    end else begin
      fwdPop <= 1'b0;
      if (revPush & revReady) begin
        revPush <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          // format is latched only between words
          if (selActive & ((readEnable & fwdValid) | writeEnable)) begin
            width_q <= widthPins;
            big_q <= ~endianSelectN;
            dirWrite_q <= writeEnable;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // reorder select is only valid during this one cycle
          reorder_q <= reorderPins;
          piece_q <= 2'h1;
          if (dirWrite_q) begin
            state_q <= ST_XFER;
          end else begin
            word_q <= fwdReordered;
            portBDataOut <= outNext;
            fwdPop <= 1'b1;
            if (width_q == `PBS_WIDTH_LONG ||
                width_q == `PBS_WIDTH_MAIL) begin
              readCount_q <= readCount_q + countOne;
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_XFER;
            end
          end
        end
        ST_XFER: begin
          if (dirWrite_q) begin
            if (gatherDone) begin
              revData <= revReordered;
              revPush <= 1'b1;
              writeCount_q <= writeCount_q + countOne;
              state_q <= ST_IDLE;
            end else if (xferWrite & ~narrowWrite) begin
              if (width_q == `PBS_WIDTH_MAIL) begin
                mailbox_q <= portBDataIn;
              end else begin
                revData <= revReordered;
                revPush <= 1'b1;
                writeCount_q <= writeCount_q + countOne;
              end
              state_q <= ST_IDLE;
            end
          end else if (selActive & readEnable) begin
            portBDataOut <= outNext;
            piece_q <= piece_q + 2'h1;
            if (lastPiece) begin
              readCount_q <= readCount_q + countOne;
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // software flush abandons a cut word, whatever its direction
      if (flush_q) begin
        state_q <= ST_IDLE;
      end
      // a new mail write wins over a software read in the same cycle
      if (mailWrite) begin
        mailboxFull <= 1'b1;
      end else if (mailboxClear) begin
        mailboxFull <= 1'b0;
      end
      // busy tracks a push still waiting on the reverse queue
      portBBusy <= (revPush & ~revReady) |
        ((state_q == ST_XFER) & dirWrite_q & (gatherDone |
          (xferWrite & ~narrowWrite & width_q != `PBS_WIDTH_MAIL)));
    end
  end

  // ==========================================================
  // register bus slave
  // one wait cycle on every access keeps read data straight from flops
  wire busReq = avs_read | avs_write;
  wire busDone = busReq & ~avs_waitrequest;
  // status fields from bit 0 upward, reserved gaps read as zero
  wire [31:0] statusWord = {
    11'h0,
    mailboxFull,
    portBBusy,
    dirWrite_q,
    big_q,
    reorder_q,
    width_q,
    2'h0,
    piece_q,
    gatherCount,
    3'h0,
    state_q
  };
  reg [31:0] readMux;

  always @* begin
    mailboxClear = busDone & avs_read & (avs_address == `PBS_REG_MAILBOX);
    case (avs_address)
      `PBS_REG_CTRL: readMux = {30'h0, 1'b0, enable_q};
      `PBS_REG_STATUS: readMux = statusWord;
      `PBS_REG_MAILBOX: readMux = mailbox_q[31:0];
      `PBS_REG_COUNT: readMux = {readCount_q, writeCount_q};
      default: readMux = 32'h0;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      enable_q <= `PBS_CTRL_RESET;
      flush_q <= 1'b0;
    end else begin
      flush_q <= 1'b0;
      if (busReq & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= readMux;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (busDone & avs_write & (avs_address == `PBS_REG_CTRL)) begin
        enable_q <= avs_writedata[`PBS_CTRL_ENABLE_BIT];
        flush_q <= avs_writedata[`PBS_CTRL_FLUSH_BIT];
      end
    end
  end

endmodule

// File: rtl/pbs_regs.vh
`ifndef PBS_REGS_VH
`define PBS_REGS_VH

// ==========================================================
// port-B format codes, taken as {select_hi, select_lo}
`define PBS_WIDTH_LONG 2'h0
`define PBS_WIDTH_BYTE 2'h1
`define PBS_WIDTH_HALF 2'h2
`define PBS_WIDTH_MAIL 2'h3

// ==========================================================
// reorder codes, taken as {select_hi, select_lo}
`define PBS_REORDER_NONE 2'h0
`define PBS_REORDER_BYTE 2'h2
`define PBS_REORDER_HALF 2'h1
`define PBS_REORDER_BOTH 2'h3

// ==========================================================
// lane geometry
`define PBS_LANE_BITS 9
`define PBS_WORD_BITS 36

// ==========================================================
// register word indices on the bus
`define PBS_REG_CTRL 3'h0
`define PBS_REG_STATUS 3'h1
`define PBS_REG_MAILBOX 3'h2
`define PBS_REG_COUNT 3'h3

// ==========================================================
// control fields and reset value
`define PBS_CTRL_ENABLE_BIT 0
`define PBS_CTRL_FLUSH_BIT 1
`define PBS_CTRL_RESET 1'h1

`endif

// File: rtl/pbs_reorder.v
`include "pbs_regs.vh"

module pbs_reorder #(
  parameter LANE = 9
) (
  // word and mode
  input wire [4*LANE-1:0] dataIn,
  input wire [1:0] mode,
  // result
  output wire [4*LANE-1:0] dataOut
);

  // ==========================================================
  // lane index mapping
  // every code is an xor on the lane index, so the same map undoes itself
  // and serves both directions
  reg [1:0] flip;

  always @* begin
    case (mode)
      `PBS_REORDER_BYTE: flip = 2'h3;
      `PBS_REORDER_HALF: flip = 2'h2;
      `PBS_REORDER_BOTH: flip = 2'h1;
      default: flip = 2'h0;
    endcase
  end

  // ==========================================================
  // whole lanes move, bits inside a lane never do
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : gLane
      assign dataOut[i*LANE +: LANE] =
        (flip == 2'h0) ? dataIn[i*LANE +: LANE] :
        (flip == 2'h1) ? dataIn[(i^1)*LANE +: LANE] :
        (flip == 2'h2) ? dataIn[(i^2)*LANE +: LANE] :
                         dataIn[(i^3)*LANE +: LANE];
    end
  endgenerate

endmodule

// File: rtl/pbs_gather.v
`include "pbs_regs.vh"

module pbs_gather #(
  parameter LANE = 9
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // control
  input wire clear,
  input wire pieceValid,
  input wire byteMode,
  input wire bigEndian,
  // narrow piece, byte in the low lane
  input wire [2*LANE-1:0] pieceData,
  // gathered entry
  output reg [4*LANE-1:0] word_q,
  output reg [2:0] count_q,
  output reg done_q
);

  // ==========================================================
  // piece placement
  wire [2:0] need = byteMode ? 3'h4 : 3'h2;
  wire [2:0] countNext = count_q + 3'h1;
  wire [1:0] bytePos = bigEndian ? (2'h3 - count_q[1:0]) : count_q[1:0];
  wire halfPos = bigEndian ? ~count_q[0] : count_q[0];

  always @(posedge clk) begin
    if (reset) begin
      word_q <= {4*LANE{1'b0}};
      count_q <= 3'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (clear) begin
        count_q <= 3'h0;
      end else if (pieceValid) begin
        if (byteMode) begin
          word_q[bytePos*LANE +: LANE] <= pieceData[LANE-1:0];
        end else begin
          word_q[halfPos*2*LANE +: 2*LANE] <= pieceData;
        end
        // entry is only released once complete
        if (countNext == need) begin
          count_q <= 3'h0;
          done_q <= 1'b1;
        end else begin
          count_q <= countNext;
        end
      end
    end
  end

endmodule

// File: testbench/pbs_sizer_chk.sv
// ========================================
// protocol checker for the port-B sizer
module pbs_sizer_chk #(
  parameter LANE = 9
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // port B and queues
  input wire portBSelectN,
  input wire readEnable,
  input wire writeEnable,
  input wire [4*LANE-1:0] portBDataOut,
  input wire fwdValid,
  input wire fwdPop,
  input wire [4*LANE-1:0] revData,
  input wire revPush,
  input wire revReady,
  input wire mailboxFull,
  // register bus
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ========================================
  // assertions
  a_pop_pulse: assert property (fwdPop |=> !fwdPop)
    else $error("queue pop wider than one cycle");
  a_pop_valid: assert property (fwdPop |-> $past(fwdValid))
    else $error("pop without a queued word");
  a_out_cause: assert property (!$stable(portBDataOut)
    |-> $past(!portBSelectN && readEnable))
    else $error("read lanes moved without a read");
  a_push_hold: assert property (revPush && !revReady
    |=> revPush && $stable(revData))
    else $error("stalled push dropped or changed");
  a_push_cause: assert property ($rose(revPush)
    |-> $past(writeEnable, 2))
    else $error("push not after a write piece");
  a_mail_clear: assert property ($fell(mailboxFull)
    |-> $past(avs_read && !avs_waitrequest && avs_address == 3'h2))
    else $error("mail flag cleared without a read");
  a_wait_answer: assert property ((avs_read || avs_write)
    && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_short: assert property (!avs_waitrequest
    |=> avs_waitrequest)
    else $error("wait low longer than one cycle");
endmodule

bind pbs_sizer pbs_sizer_chk #(.LANE(LANE)) chk_u (
  .clk(clk), .reset(reset), .portBSelectN(portBSelectN),
  .readEnable(readEnable), .writeEnable(writeEnable),
  .portBDataOut(portBDataOut), .fwdValid(fwdValid), .fwdPop(fwdPop),
  .revData(revData), .revPush(revPush), .revReady(revReady),
  .mailboxFull(mailboxFull), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest)
);

// File: testbench/pbs_far_side.sv
`include "pbs_regs.vh"
// ========================================
// far side of port B, a narrow bus master
module pbs_far_side (
  // clock
  input wire clk,
  // control pins
  output logic selN,
  output logic rdEn,
  output logic wrEn,
  output logic wLo,
  output logic wHi,
  output logic endN,
  output logic roLo,
  output logic roHi,
  // data
  output logic [35:0] busData,
  input wire [35:0] dutData
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {selN, rdEn, wrEn, wLo, wHi, endN, roLo, roHi} = 8'h80;
    busData = 36'h0;
  end
  // ========================================
  // idle lanes carry junk, never a stale copy
  function automatic logic [35:0] piece(input logic [35:0] g,
    input logic [1:0] w, input logic e, input int i);
    logic [35:0] d;
    d = ~g;
    if (w == `PBS_WIDTH_BYTE && e) d[8:0] = g[9*i +: 9];
    else if (w == `PBS_WIDTH_BYTE) d[35:27] = g[27-9*i +: 9];
    else if (w == `PBS_WIDTH_HALF && e) d[17:0] = g[18*i +: 18];
    else if (w == `PBS_WIDTH_HALF) d[35:18] = g[18-18*i +: 18];
    else d = g;
    return d;
  endfunction
  task automatic start(input logic wr, input logic [1:0] w, input logic e);
    @(posedge clk);
    selN <= 1'b0;
    rdEn <= !wr;
    wrEn <= wr;
    {wHi, wLo} <= w;
    endN <= e;
  endtask
  task automatic read_word(input logic [1:0] w, input logic e,
    input logic [1:0] ro, input int n, output logic [35:0] got [4]);
    start(1'b0, w, e);
    @(posedge clk);
    {roHi, roLo} <= ro;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      {roHi, roLo} <= 2'h0;
      if (i == n - 1) begin
        selN <= 1'b1;
        rdEn <= 1'b0;
      end
      #1 got[i] = dutData;
    end
  endtask
  task automatic write_word(input logic [1:0] w, input logic e,
    input logic [1:0] ro, input logic [35:0] g, input int n);
    start(1'b1, w, e);
    @(posedge clk);
    {roHi, roLo} <= ro;
    @(posedge clk);
    {roHi, roLo} <= 2'h0;
    busData <= piece(g, w, e, 0);
    for (int i = 1; i <= n; i++) begin
      @(posedge clk);
      if (i < n) busData <= piece(g, w, e, i);
      else begin
        selN <= 1'b1;
        wrEn <= 1'b0;
        busData <= ~busData;
      end
    end
  endtask
endmodule

// File: testbench/tb.sv
`include "pbs_regs.vh"
// ========================================
// bench top
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [1:0] w;
    logic e;
    logic [1:0] ro;
    logic [2:0] n;
  } pbs_row_t;
  logic clk, reset, revReady, fwdValid, avs_read, avs_write;
  logic [35:0] fwdData, wd, prev;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, q;
  wire selN, rdEn, wrEn, wLo, wHi, endN, roLo, roHi;
  wire [35:0] busData, portBDataOut, revData;
  wire fwdPop, revPush, portBBusy, mailboxFull, avs_waitrequest;
  wire [31:0] avs_readdata;
  logic [35:0] revQ [$];
  logic [35:0] got [4];
  int fails, testsRun, k;
  // format, endian, reorder, and the piece count each gives
  pbs_row_t rows [9] = '{
    '{`PBS_WIDTH_LONG, 1'b1, `PBS_REORDER_NONE, 3'h1},
    '{`PBS_WIDTH_LONG, 1'b0, `PBS_REORDER_BOTH, 3'h1},
    '{`PBS_WIDTH_HALF, 1'b1, `PBS_REORDER_HALF, 3'h2},
    '{`PBS_WIDTH_HALF, 1'b0, `PBS_REORDER_BYTE, 3'h2},
    '{`PBS_WIDTH_HALF, 1'b0, `PBS_REORDER_NONE, 3'h2},
    '{`PBS_WIDTH_BYTE, 1'b1, `PBS_REORDER_BYTE, 3'h4},
    '{`PBS_WIDTH_BYTE, 1'b0, `PBS_REORDER_BOTH, 3'h4},
    '{`PBS_WIDTH_BYTE, 1'b1, `PBS_REORDER_NONE, 3'h4},
    '{`PBS_WIDTH_MAIL, 1'b1, `PBS_REORDER_HALF, 3'h1}};
  pbs_sizer dut_u (
    .clk(clk), .reset(reset), .portBSelectN(selN), .readEnable(rdEn),
    .writeEnable(wrEn), .widthSelectLo(wLo), .widthSelectHi(wHi),
    .endianSelectN(endN), .reorderSelectLo(roLo), .reorderSelectHi(roHi),
    .portBDataIn(busData), .portBDataOut(portBDataOut),
    .portBBusy(portBBusy), .fwdData(fwdData), .fwdValid(fwdValid),
    .fwdPop(fwdPop), .revData(revData), .revPush(revPush),
    .revReady(revReady), .mailboxFull(mailboxFull),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  pbs_far_side far_u (
    .clk(clk), .selN(selN), .rdEn(rdEn), .wrEn(wrEn), .wLo(wLo),
    .wHi(wHi), .endN(endN), .roLo(roLo), .roHi(roHi),
    .busData(busData), .dutData(portBDataOut));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // queue ends: a popped head shows junk
  always @(posedge clk) begin
    if (fwdPop) begin
      fwdValid <= 1'b0;
      fwdData <= ~fwdData;
    end
    if (revPush && revReady) revQ.push_back(revData);
  end
  // ========================================
  // expectations
  function automatic logic [35:0] reord(input logic [35:0] v,
    input logic [1:0] c);
    case (c)
      `PBS_REORDER_BYTE: return {v[8:0], v[17:9], v[26:18], v[35:27]};
      `PBS_REORDER_HALF: return {v[17:0], v[35:18]};
      `PBS_REORDER_BOTH: return {v[26:18], v[35:27], v[8:0], v[17:9]};
      default: return v;
    endcase
  endfunction
  function automatic logic [35:0] lanes(input logic [35:0] p, r,
    input pbs_row_t c, input int i);
    if (c.w == `PBS_WIDTH_BYTE && c.e) p[8:0] = r[9*i +: 9];
    else if (c.w == `PBS_WIDTH_BYTE) p[35:27] = r[27-9*i +: 9];
    else if (c.w == `PBS_WIDTH_HALF && c.e) p[17:0] = r[18*i +: 18];
    else if (c.w == `PBS_WIDTH_HALF) p[35:18] = r[18-18*i +: 18];
    else p = r;
    return p;
  endfunction
  // ========================================
  // tasks
  task automatic check(input logic [35:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic avAccess(input logic wr, input logic [2:0] a,
    input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) fails++;
    if (k >= 20) give_verdict();
    @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic expectRev(input logic [35:0] exp);
    for (k = 0; revQ.size() == 0 && k < 30; k++) @(posedge clk);
    if (k >= 30) fails++;
    if (k >= 30) give_verdict();
    check(revQ.pop_front(), exp);
  endtask
  // ========================================
  // main sequence
  initial begin
    reset = 1'b1;
    {revReady, fwdValid, avs_read, avs_write} = 4'h8;
    {fwdData, avs_address, avs_writedata} = '0;
    fails = 0;
    testsRun = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    avAccess(1'b1, 3'h5, 32'hffff_ffff);
    avAccess(1'b0, 3'h5, 32'h0);
    check(q, 32'h0);
    avAccess(1'b0, `PBS_REG_CTRL, 32'h0);
    check(q, 32'h1);
    foreach (rows[i]) begin
      wd = 36'h123456789 * (i + 1);
      @(posedge clk);
      fwdData <= wd;
      fwdValid <= 1'b1;
      prev = portBDataOut;
      far_u.read_word(rows[i].w, rows[i].e, rows[i].ro, rows[i].n, got);
      for (int j = 0; j < rows[i].n; j++) begin
        prev = lanes(prev, reord(wd, rows[i].ro), rows[i], j);
        check(got[j], prev);
      end
      repeat (2) @(posedge clk);
      check(fwdValid, 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      wd = 36'h2468ace13 * (i + 3);
      far_u.write_word(rows[i].w, rows[i].e, rows[i].ro, wd, rows[i].n);
      expectRev(reord(wd, rows[i].ro));
    end
    far_u.write_word(`PBS_WIDTH_MAIL, 1'b1, 2'h0, 36'h9abcdef01, 1);
    repeat (2) @(posedge clk);
    check(mailboxFull, 1'b1);
    check(revPush, 1'b0);
    avAccess(1'b0, `PBS_REG_MAILBOX, 32'h0);
    check(q, 32'habcdef01);
    @(posedge clk);
    check(mailboxFull, 1'b0);
    avAccess(1'b0, `PBS_REG_COUNT, 32'h0);
    check(q[31:16], 16'h9);
    check(q[15:0], 16'h8);
    // port B switched off: a read request must be ignored
    avAccess(1'b1, `PBS_REG_CTRL, 32'h2);
    fwdValid <= 1'b1;
    far_u.read_word(`PBS_WIDTH_LONG, 1'b1, 2'h0, 1, got);
    repeat (2) @(posedge clk);
    check(fwdValid, 1'b1);
    check(got[0], prev);
    avAccess(1'b1, `PBS_REG_CTRL, 32'h1);
    // stalled reverse queue: push must wait
    revReady <= 1'b0;
    far_u.write_word(`PBS_WIDTH_LONG, 1'b0, `PBS_REORDER_BYTE, wd, 1);
    repeat (4) @(posedge clk);
    check(revPush, 1'b1);
    check(portBBusy, 1'b1);
    revReady <= 1'b1;
    expectRev(reord(wd, `PBS_REORDER_BYTE));
    far_u.write_word(`PBS_WIDTH_MAIL, 1'b0, 2'h0, wd, 1);
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    check(mailboxFull, 1'b0);
    check(avs_waitrequest, 1'b1);
    reset <= 1'b0;
    @(posedge clk);
    check(portBDataOut, 36'h0);
    avAccess(1'b0, `PBS_REG_STATUS, 32'h0);
    check(q, 32'h1);
    give_verdict();
  end
endmodule
